// *** core/term_match.sv ***
// one sequencer term compare: masked equality on the low part of a state
// assumes value and mask come from registers on the same clock
`timescale 1ns/1ns
`default_nettype none
module term_match
    import trace_pkg::*;
(
    input  wire logic [STATE_W-1:0] sample_i,
    input  wire logic [TERM_W-1:0]  value_i,
    input  wire logic [TERM_W-1:0]  mask_i,
    output logic                    hit_o
);
    // a zero mask matches any state, which is the default after reset
    assign hit_o = ((sample_i[TERM_W-1:0] ^ value_i) & mask_i) == '0;
endmodule // term_match
`default_nettype wire

// *** core/trace_capture_sequencer.sv ***
// state-capture trace engine: sampling, trigger sequencer, trace memory, status
// assumes an apb master on clk_i; bus lines and arm come from outside the domain
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
module trace_capture_sequencer
    import trace_pkg::*;
#(
    parameter int ATT_MAX_CYCLES = trace_pkg::ATT_MAX_CYC
) (
    input  wire logic                          clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [trace_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]                   pwdata_i,
    output logic      [31:0]                   prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    input  wire logic [trace_pkg::STATE_W-1:0] bus_state_i,
    input  wire logic                          arm_i,
    output logic                               trig_out_o,
    output logic                               irq_o
);
    import trace_pkg::*;

    localparam logic [ATT_W-1:0] ATT_SAT = ATT_W'(ATT_MAX_CYCLES + 1);
    localparam logic [ATT_W-1:0] ATT_MAX = ATT_W'(ATT_MAX_CYCLES);
    localparam logic [ATT_W-1:0] ATT_NEG = ATT_W'(ATT_NEG_CYC);

    typedef struct packed {
        logic [STATE_W-1:0]                 bus_s1;
        logic [STATE_W-1:0]                 bus_s2;
        logic [2:0]                         arm_s;
        run_state_t                         run;
        logic                               arm_en;
        logic [TSEL_W-1:0]                  last_term;
        logic [TSEL_W-1:0]                  term_sel;
        logic [N_TERMS-1:0][TERM_W-1:0]     tval;
        logic [N_TERMS-1:0][TERM_W-1:0]     tmask;
        logic [N_TERMS-1:0][OCC_W-1:0]      tocc;
        logic [TNUM_W-1:0]                  term;
        logic                               term_chg;
        logic [OCC_W-1:0]                   occ_left;
        logic                               trig;
        logic                               trig_out;
        logic                               arm_rcv;
        logic [CNT_W-1:0]                   count;
        logic [ATT_W-1:0]                   att_cnt;
        logic [ATT_W-1:0]                   att_val;
        logic                               att_under;
        logic                               att_over;
        logic [IRQ_W-1:0]                   irq_stat;
        logic [IRQ_W-1:0]                   irq_mask;
        logic                               irq;
        logic [IDX_W-1:0]                   rd_idx;
        logic [31:0]                        prdata;
        logic                               pready;
        logic                               pslverr;
    } st_t;

    // reset leaves every mask zero and every occurrence at one
    localparam st_t ST_RST = '{run: RS_HALT, tocc: {N_TERMS{OCC_RST}}, default: '0};

    st_t                q;
    st_t                d;
    logic               hit;
    logic               mem_we;
    logic [IDX_W-1:0]   mem_addr;
    logic [STATE_W-1:0] rd_data;
    logic               setup;
    logic               fire;
    logic               wr;
    logic               start;
    logic               halt;
    logic               arm_edge;
    logic [IRQ_W-1:0]   ev;
    logic [1:0]         run_code;
    logic [1:0]         arm_code;
    logic [TNUM_W-1:0]  term_rep;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= OFS_RHI);
    endfunction

    // compare against the term the sequencer sits in
    term_match u_match (
        .sample_i (q.bus_s2),
        .value_i  (q.tval[q.term[TSEL_W-1:0]]),
        .mask_i   (q.tmask[q.term[TSEL_W-1:0]]),
        .hit_o    (hit)
    );

    trace_store u_store (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .we_i    (mem_we),
        .waddr_i (mem_addr),
        .wdata_i (q.bus_s2),
        .raddr_i (q.rd_idx),
        .rdata_o (rd_data)
    );

    // status decode shared by the read mux
    always_comb begin
        run_code = (q.run == RS_RUN) ? RC_RUNNING : (q.run == RS_DONE) ? RC_DONE : RC_HALTED;
        arm_code = !q.arm_en ? AC_IGNORED : (q.arm_rcv ? AC_RCVD : AC_NOT);
        term_rep = q.term;
    end

    // whole next state: sync, bus slave, sequencer, interval, interrupts
    always_comb begin
        d        = q;
        mem_we   = 1'b0;
        mem_addr = q.count[IDX_W-1:0];
        ev       = '0;
        // two flops on outside inputs; edge taken past the second
        d.bus_s1 = bus_state_i;
        d.bus_s2 = q.bus_s1;
        d.arm_s  = {q.arm_s[1:0], arm_i};
        arm_edge = q.arm_s[1] & ~q.arm_s[2];
        setup    = psel_i & ~penable_i;
        fire     = psel_i & penable_i & q.pready;
        wr       = fire & pwrite_i;
        start    = wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_START];
        halt     = wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_HALT];
        // no wait state: data registered in setup, pready in the first access cycle
        d.pready  = setup;
        d.pslverr = setup & ~mapped(paddr_i);
        if (setup) begin
            case (paddr_i)
                OFS_CTRL:  d.prdata = 32'({q.last_term, 1'b0, q.arm_en, 2'h0});
                OFS_TSEL:  d.prdata = 32'(q.term_sel);
                OFS_TVAL:  d.prdata = q.tval[q.term_sel];
                OFS_TMASK: d.prdata = q.tmask[q.term_sel];
                OFS_TOCC:  d.prdata = 32'(q.tocc[q.term_sel]);
                OFS_STAT:  d.prdata = 32'({q.term_chg & (q.run == RS_RUN), term_rep, q.trig, arm_code, run_code});
                OFS_ATT:   d.prdata = {5'h00, q.att_over, q.att_under,
                                       ~q.arm_en | ~q.trig | ~q.arm_rcv, q.att_val};
                OFS_STORE: d.prdata = {6'h00, (q.count == '0) ? CNT_W'(0) : q.count - CNT_W'(1),
                                       6'h00, q.count};
                OFS_DEPTH: d.prdata = 32'(DEPTH);
                OFS_OCCL:  d.prdata = 32'(q.occ_left);
                OFS_ISTAT: d.prdata = 32'(q.irq_stat);
                OFS_IMASK: d.prdata = 32'(q.irq_mask);
                OFS_RIDX:  d.prdata = 32'(q.rd_idx);
                OFS_RLO:   d.prdata = rd_data[31:0];
                OFS_RHI:   d.prdata = rd_data[63:32];
                default:   d.prdata = 32'h0000_0000;
            endcase
        end
        // register writes land at the completing edge only
        if (wr) begin
            case (paddr_i)
                OFS_CTRL: begin
                    d.arm_en    = pwdata_i[CTRL_ARMEN];
                    d.last_term = pwdata_i[CTRL_LAST+:TSEL_W];
                end
                OFS_TSEL:  d.term_sel = pwdata_i[TSEL_W-1:0];
                OFS_TVAL:  d.tval[q.term_sel] = pwdata_i;
                OFS_TMASK: d.tmask[q.term_sel] = pwdata_i;
                OFS_TOCC:  d.tocc[q.term_sel] = pwdata_i[OCC_W-1:0];
                OFS_ISTAT: d.irq_stat = q.irq_stat & ~pwdata_i[IRQ_W-1:0];
                OFS_IMASK: d.irq_mask = pwdata_i[IRQ_W-1:0];
                OFS_RIDX:  d.rd_idx = pwdata_i[IDX_W-1:0];
                default: begin
                end
            endcase
        end
        // sequencer; start outranks a halt written with it
        if (start) begin
            d.run      = RS_RUN;
            d.count    = '0;
            d.trig     = 1'b0;
            d.trig_out = 1'b0;
            d.arm_rcv  = 1'b0;
            d.term     = '0;
            d.occ_left = q.tocc[0];
            d.att_cnt  = '0;
            d.att_val  = '0;
            d.att_under = 1'b0;
            d.att_over = 1'b0;
        end else if (halt) begin
            d.trig_out = 1'b0;
            if (q.run == RS_RUN) begin
                d.run = RS_HALT;
            end
        end else begin
            case (q.run)
                RS_RUN: begin
                    if (!q.trig) begin
                        if (hit) begin
                            if (q.occ_left <= OCC_W'(1)) begin
                                if (q.term == TNUM_W'(q.last_term)) begin
                                    // leaving the last term is the trigger
                                    mem_we     = 1'b1;
                                    mem_addr   = '0;
                                    d.count    = CNT_W'(1);
                                    d.trig     = 1'b1;
                                    d.trig_out = 1'b1;
                                    d.term     = q.term + TNUM_W'(1);
                                    ev[IRQ_TRIG] = 1'b1;
                                    if (DEPTH == 1) begin
                                        d.run = RS_DONE;
                                    end
                                end else begin
                                    d.term     = q.term + TNUM_W'(1);
                                    d.occ_left = q.tocc[q.term[TSEL_W-1:0] + TSEL_W'(1)];
                                end
                            end else begin
                                d.occ_left = q.occ_left - OCC_W'(1);
                            end
                        end
                    end else begin
                        mem_we  = 1'b1;
                        d.count = q.count + CNT_W'(1);
                        if (q.count == CNT_W'(DEPTH - 1)) begin
                            d.run = RS_DONE;
                            ev[IRQ_DONE] = 1'b1;
                        end
                    end
                end
                RS_DONE, RS_HALT: begin
                end
                default: d.run = RS_HALT;
            endcase
        end
        d.term_chg = d.term != q.term;
        // arm is sticky since start, whatever the run state
        if (arm_edge) begin
            d.arm_rcv = 1'b1;
            ev[IRQ_ARM] = 1'b1;
        end
        // interval counter runs while exactly one of arm and trigger is seen
        if (!start) begin
            if ((q.arm_rcv ^ q.trig) && q.att_cnt != ATT_SAT) begin
                d.att_cnt = q.att_cnt + ATT_W'(1);
            end
            if (ev[IRQ_TRIG]) begin
                if (q.arm_rcv) begin
                    d.att_val  = q.att_cnt;
                    d.att_over = q.att_cnt > ATT_MAX;
                end else begin
                    d.att_cnt = '0;
                end
            end else if (arm_edge && q.trig && !q.arm_rcv) begin
                // arm after the trigger gives a negative interval
                d.att_val   = ATT_W'(0) - q.att_cnt;
                d.att_under = q.att_cnt > ATT_NEG;
            end
        end
        // a new event beats a clear in the same cycle
        d.irq_stat = d.irq_stat | ev;
        d.irq      = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata_o   = q.prdata;
    assign pready_o   = q.pready;
    assign pslverr_o  = q.pslverr;
    assign trig_out_o = q.trig_out;
    assign irq_o      = q.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    run_onehot_a: assert property ($onehot(q.run))
        else $error("run state not one of three");
    start_clears_a: assert property (start |=> q.run == RS_RUN && q.count == '0 && !q.trig
                                     && q.term == '0 && q.occ_left == $past(q.tocc[0]))
        else $error("start did not reset the measurement");
    halt_stops_a: assert property (halt && !start && q.run == RS_RUN |=> q.run == RS_HALT)
        else $error("halt did not stop a running trace");
    halt_output_a: assert property (halt && !start |=> !trig_out_o)
        else $error("trigger output still high after halt");
    trig_line_a: assert property (q.run == RS_RUN && !q.trig && !start && !halt && hit
                                  && q.occ_left <= OCC_W'(1) && q.term == TNUM_W'(q.last_term)
                                  |-> mem_we && mem_addr == '0 ##1 q.trig && q.count == CNT_W'(1))
        else $error("trigger state not stored at line 0");
    store_step_a: assert property (q.run == RS_RUN && q.trig && !start && !halt
                                   |-> mem_we ##1 q.count == $past(q.count) + CNT_W'(1))
        else $error("stored state count did not advance");
    full_done_a: assert property (q.run == RS_RUN && q.trig && !start && !halt
                                  && q.count == CNT_W'(DEPTH - 1) |=> q.run == RS_DONE)
        else $error("full memory did not complete trace");
    done_term_a: assert property (q.run == RS_DONE |-> term_rep == TNUM_W'(q.last_term) + TNUM_W'(1))
        else $error("completed trace reports wrong term");
    halt_term_a: assert property (q.run == RS_HALT && !start |=> $stable(q.term))
        else $error("term moved while halted");
    occ_count_a: assert property (q.run == RS_RUN && !q.trig && hit && !start && !halt
                                  && q.occ_left > OCC_W'(1) |=> q.occ_left == $past(q.occ_left) - OCC_W'(1))
        else $error("occurrence count did not step down");
    arm_sticky_a: assert property (arm_edge |=> q.arm_rcv ##1 (q.arm_rcv || $past(start)))
        else $error("arm received flag lost");
    arm_under_a: assert property (arm_edge && q.trig && !q.arm_rcv && !start && q.att_cnt > ATT_NEG
                                  |=> q.att_under)
        else $error("late arm not flagged underrange");

    trig_seen_c: cover property (q.run == RS_RUN && !q.trig ##1 q.trig);
    done_seen_c: cover property (q.run == RS_RUN ##1 q.run == RS_DONE);
    halt_seen_c: cover property (q.run == RS_RUN && q.trig ##1 q.run == RS_HALT);
    arm_seen_c:  cover property (q.arm_en && arm_edge ##[1:20] q.trig);
endmodule // trace_capture_sequencer
`default_nettype wire

// *** core/trace_store.sv ***
// trace memory held in flip-flops, one write port and one indexed read port
// assumes writer and reader share clk_i
`timescale 1ns/1ns
`default_nettype none
module trace_store
    import trace_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    input  wire logic               we_i,
    input  wire logic [IDX_W-1:0]   waddr_i,
    input  wire logic [STATE_W-1:0] wdata_i,
    input  wire logic [IDX_W-1:0]   raddr_i,
    output logic      [STATE_W-1:0] rdata_o
);
    typedef struct packed {
        logic [DEPTH-1:0][STATE_W-1:0] mem;
    } store_t;

    store_t q;
    store_t d;

    // write one line per cycle at most
    always_comb begin
        d = q;
        if (we_i) begin
            d.mem[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // read is combinational so a read register sees the line at once
    assign rdata_o = q.mem[raddr_i];
endmodule // trace_store
`default_nettype wire

// *** dv/bus_source.sv ***
// far-side model: emulated processor bus and arm line
// assumes one clock shared with the analyzer; arm follows the bench request
`timescale 1ns/1ns
`default_nettype none
module bus_source (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        arm_req_i,
    output logic      [63:0] bus_o,
    output logic             arm_o
);
    logic [31:0] cnt_q;
    // a new bus cycle every clock; upper half is the complement of the lower so stored lines can be checked
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
    assign bus_o = {~cnt_q, cnt_q};
    assign arm_o = arm_req_i;
endmodule // bus_source
`default_nettype wire

// *** dv/test_trace_capture_sequencer.sv ***
// bench: drives apb and the bus model, checks status after each scenario
// assumes the package trace_pkg; the apb master waits for pready however long it takes
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_trace_capture_sequencer;
    import trace_pkg::*;
    logic        clk_i, nrst_i, psel, penable, pwrite, arm_req, pready, pslverr, arm, trig, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, lo;
    logic [63:0] bus;
    int          mismatches, comparisons, cyc;
    trace_capture_sequencer u_trace_capture_sequencer (.clk_i(clk_i), .nrst_i(nrst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus_state_i(bus),
        .arm_i(arm), .trig_out_o(trig), .irq_o(irq));
    bus_source u_bus_source (.clk_i(clk_i), .nrst_i(nrst_i), .arm_req_i(arm_req), .bus_o(bus),
        .arm_o(arm));
    // clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // apb transfer; answer taken at the rising edge that sees pready, request released at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wait_trig();
        for (int i = 0; i < 50 && trig !== 1'b1; i++) @(negedge clk_i);
    endtask
    task automatic reset_values();
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("run", RC_HALTED, r[1:0])
        `CHK("arm", AC_IGNORED, r[3:2])
        apb(1'b0, OFS_DEPTH, 32'h0);
        `CHK("depth", 32'd512, r)
        apb(1'b0, 8'h3c, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, OFS_IMASK, 32'h0000_0003);
    endtask
    task automatic default_trace();
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        wait_trig();
        `CHK("trig", 1'b1, trig)
        for (int i = 0; i < 300; i++) begin
            apb(1'b0, OFS_STAT, 32'h0);
            if (r[1:0] != RC_RUNNING) break;
        end
        `CHK("done", RC_DONE, r[1:0])
        `CHK("term", 3'h1, r[7:5])
        apb(1'b0, OFS_STORE, 32'h0);
        `CHK("count", 10'd512, r[9:0])
        `CHK("last", 10'd511, r[25:16])
        apb(1'b0, OFS_ATT, 32'h0);
        `CHK("att_unk", 1'b1, r[ATT_UNK])
        `CHK("irq", 1'b1, irq)
        apb(1'b1, OFS_ISTAT, 32'h0000_0007);
        apb(1'b1, OFS_RIDX, 32'h0);
        apb(1'b0, OFS_RLO, 32'h0);
        lo = ~r;
        apb(1'b0, OFS_RHI, 32'h0);
        `CHK("line0", lo, r)
        `CHK("irq_clr", 1'b0, irq)
    endtask
    task automatic halt_trace();
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        wait_trig();
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        @(negedge clk_i);
        `CHK("trig_off", 1'b0, trig)
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("halted", RC_HALTED, r[1:0])
        `CHK("in_mem", 1'b1, r[ST_TRIG])
    endtask
    task automatic held_term();
        apb(1'b1, OFS_TMASK, 32'hffff_ffff);
        apb(1'b1, OFS_TVAL, 32'hffff_ffff);
        apb(1'b1, OFS_TOCC, 32'h0000_0003);
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("running", RC_RUNNING, r[1:0])
        `CHK("arm_not", AC_NOT, r[3:2])
        `CHK("no_trig", 1'b0, r[ST_TRIG])
        apb(1'b0, OFS_OCCL, 32'h0);
        `CHK("occl", 32'd3, r)
        apb(1'b0, OFS_STORE, 32'h0);
        `CHK("cleared", 10'd0, r[9:0])
        apb(1'b1, OFS_CTRL, 32'h0000_0006);
        arm_req <= 1'b1;
        repeat (4) @(posedge clk_i);
        arm_req <= 1'b0;
        repeat (4) @(posedge clk_i);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("term_hold", 3'h0, r[7:5])
        `CHK("arm_rcvd", AC_RCVD, r[3:2])
        apb(1'b0, OFS_ATT, 32'h0);
        `CHK("att_none", 1'b1, r[ATT_UNK])
    endtask
    // two terms: term 0 needs two matches, term 1 one; trigger leaves term 1
    task automatic two_terms();
        apb(1'b1, OFS_TMASK, 32'h0);
        apb(1'b1, OFS_TOCC, 32'h0000_0002);
        apb(1'b1, OFS_TSEL, 32'h0000_0001);
        apb(1'b1, OFS_TOCC, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0011);
        wait_trig();
        `CHK("trig_two", 1'b1, trig)
        apb(1'b1, OFS_CTRL, 32'h0000_0012);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("term_two", 3'h2, r[7:5])
        `CHK("halted_two", RC_HALTED, r[1:0])
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl_rd", 32'h0000_0010, r)
    endtask
    // main sequence
    initial begin
        {nrst_i, psel, penable, pwrite, arm_req} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        reset_values();
        default_trace();
        halt_trace();
        held_term();
        two_terms();
        results();
    end
endmodule // test_trace_capture_sequencer
`default_nettype wire

// *** include/trace_pkg.sv ***
// constants, field layouts and state encodings of the trace capture sequencer
// assumes a single 100 MHz clock domain and a 32-bit apb register bus
package trace_pkg;
    localparam int STATE_W = 64;   // sampled bus and control lines
    localparam int TERM_W  = 32;   // low part of a state compared by a term
    localparam int N_TERMS = 4;
    localparam int TSEL_W  = 2;
    localparam int TNUM_W  = 3;    // term number, one past the last fits
    localparam int DEPTH   = 512;  // total storable states
    localparam int IDX_W   = 9;
    localparam int CNT_W   = 10;
    localparam int OCC_W   = 16;
    localparam int ATT_W   = 24;
    localparam int ADDR_W  = 8;
    localparam int IRQ_W   = 3;

    localparam int CLK_NS      = 10;
    localparam int ATT_NEG_NS  = 40;        // -0.04 us
    localparam int ATT_MAX_NS  = 41943000;  // 41.943 ms
    localparam int ATT_NEG_CYC = ATT_NEG_NS / CLK_NS;
    localparam int ATT_MAX_CYC = ATT_MAX_NS / CLK_NS;

    localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TSEL  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TVAL  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TMASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_TOCC  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_ATT   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STORE = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_DEPTH = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_OCCL  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_RIDX  = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_RLO   = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_RHI   = 8'h38;

    localparam int CTRL_START = 0;
    localparam int CTRL_HALT  = 1;
    localparam int CTRL_ARMEN = 2;
    localparam int CTRL_LAST  = 4;  // two bits: number of the last term
    localparam int IRQ_TRIG   = 0;
    localparam int IRQ_DONE   = 1;
    localparam int IRQ_ARM    = 2;
    localparam int ST_RUN     = 0;  // two bits
    localparam int ST_ARM     = 2;  // two bits
    localparam int ST_TRIG    = 4;
    localparam int ST_TERM    = 5;  // three bits
    localparam int ST_TUNK    = 8;
    localparam int ATT_UNK    = 24;
    localparam int ATT_UNDER  = 25;
    localparam int ATT_OVER   = 26;
    localparam int STO_LAST   = 16;

    localparam logic [OCC_W-1:0]  OCC_RST  = 16'h0001;
    localparam logic [TERM_W-1:0] MASK_RST = 32'h0000_0000;
    localparam logic [1:0] RC_RUNNING = 2'h0;
    localparam logic [1:0] RC_DONE    = 2'h1;
    localparam logic [1:0] RC_HALTED  = 2'h2;
    localparam logic [1:0] AC_IGNORED = 2'h0;
    localparam logic [1:0] AC_NOT     = 2'h1;
    localparam logic [1:0] AC_RCVD    = 2'h2;

    typedef enum logic [2:0] {
        RS_RUN  = 3'b001,
        RS_DONE = 3'b010,
        RS_HALT = 3'b100
    } run_state_t;
endpackage
